// ===== rtl/swap_retry_pkg.sv
package swap_retry_pkg;

  // Host register offsets
  localparam logic [7:0] OFF_RETRY = 8'h08;
  localparam logic [7:0] OFF_SWAP_NEW = 8'h0c;
  localparam logic [7:0] OFF_SWAP_EXP = 8'h10;
  localparam logic [7:0] OFF_SWAP_CTL = 8'h14;

  // Field positions and widths
  localparam int LIMIT_W = 4;
  localparam int PHYS_LIMIT_LSB = 8;
  localparam int ATRESP_LIMIT_LSB = 4;
  localparam int ATREQ_LIMIT_LSB = 0;
  localparam int LIMITS_W = 12;
  localparam int DONE_BIT = 31;
  localparam int SEL_W = 2;

  // Reset values
  localparam logic [LIMITS_W-1:0] LIMITS_RST = 12'h000;
  localparam logic [31:0] SWAP_WORD_RST = 32'h0000_0000;
  localparam logic DONE_RST = 1'b1;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

  // Transmit unit index
  localparam int UNIT_AT_REQ = 0;
  localparam int UNIT_AT_RESP = 1;
  localparam int UNIT_PHYS_RESP = 2;
  localparam int NUM_UNITS = 3;

  typedef enum logic [1:0] {
    RES_BUS_MANAGER_ID = 2'h0,
    RES_BANDWIDTH_AVAILABLE = 2'h1,
    RES_CHANNELS_AVAILABLE_HI = 2'h2,
    RES_CHANNELS_AVAILABLE_LO = 2'h3
  } bus_resource_t;

  typedef enum logic [1:0] {
    SW_IDLE = 2'b01,
    SW_BUSY = 2'b10
  } swap_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } host_rsp_t;

  typedef struct packed {
    logic start;
    logic ack;
    logic retryable;
  } tx_event_t;

  typedef struct packed {
    logic retry;
    logic exhausted;
  } tx_verdict_t;

  typedef struct packed {
    swap_state_t sw;
    logic [LIMITS_W-1:0] limits;
    logic [31:0] swap_new;
    logic [31:0] swap_exp;
    logic done;
    logic [SEL_W-1:0] sel;
    logic hit;
    logic [3:0][31:0] res;
    logic [NUM_UNITS-1:0][LIMIT_W-1:0] cnt;
    logic [NUM_UNITS-1:0] retry;
    logic [NUM_UNITS-1:0] exhausted;
    host_rsp_t rsp;
  } regs_t;

endpackage

// ===== rtl/async_retry_and_csr_swap_regs.sv
`timescale 1ns/1ps
`default_nettype none

module async_retry_and_csr_swap_regs
  import swap_retry_pkg::*;
#(
  parameter logic [3:0][31:0] RES_RST = '0
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Host register port
  input wire host_req_t host_req_in,
  output host_rsp_t host_rsp_out,
  // Transmit units
  input wire tx_event_t [NUM_UNITS-1:0] tx_event_in,
  output tx_verdict_t [NUM_UNITS-1:0] tx_verdict_out,
  // Bus-management resources
  output logic [3:0][31:0] bus_resource_out,
  output logic swap_match_out
);

  localparam regs_t RST_STATE = '{
    sw: SW_IDLE,
    limits: LIMITS_RST,
    swap_new: SWAP_WORD_RST,
    swap_exp: SWAP_WORD_RST,
    done: DONE_RST,
    sel: SEL_RST,
    hit: 1'b0,
    res: RES_RST,
    cnt: '0,
    retry: '0,
    exhausted: '0,
    rsp: '0
  };

  regs_t q;
  regs_t d;

  function automatic logic [LIMIT_W-1:0] limit_of(
    input logic [LIMITS_W-1:0] lim,
    input int unit
  );
    logic [LIMIT_W-1:0] r;
    r = '0;
    case (unit)
      UNIT_AT_REQ: r = lim[ATREQ_LIMIT_LSB +: LIMIT_W];
      UNIT_AT_RESP: r = lim[ATRESP_LIMIT_LSB +: LIMIT_W];
      UNIT_PHYS_RESP: r = lim[PHYS_LIMIT_LSB +: LIMIT_W];
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] read_word(
    input regs_t s,
    input logic [7:0] addr
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      // Upper twenty bits stay zero: no dual-phase retry, reserved
      OFF_RETRY: w[LIMITS_W-1:0] = s.limits;
      OFF_SWAP_NEW: w = s.swap_new;
      OFF_SWAP_EXP: w = s.swap_exp;
      OFF_SWAP_CTL: begin
        w[DONE_BIT] = s.done;
        w[SEL_W-1:0] = s.sel;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    d = q;
    d.rsp.valid = 1'b0;
    d.retry = '0;
    d.exhausted = '0;

    if (host_req_in.rd) begin
      d.rsp.valid = 1'b1;
      d.rsp.data = read_word(q, host_req_in.addr);
    end

    if (host_req_in.wr) begin
      case (host_req_in.addr)
        OFF_RETRY: d.limits = host_req_in.wdata[LIMITS_W-1:0];
        OFF_SWAP_NEW: d.swap_new = host_req_in.wdata;
        OFF_SWAP_EXP: d.swap_exp = host_req_in.wdata;
        OFF_SWAP_CTL: begin
          // Ignored while busy, so finishing never races a new clear
          if (q.sw == SW_IDLE) begin
            d.done = 1'b0;
            d.sel = host_req_in.wdata[SEL_W-1:0];
            d.sw = SW_BUSY;
          end
        end
        default: d.sw = q.sw;
      endcase
    end

    // Compare and store in one cycle, so nothing can slip in between
    case (q.sw)
      SW_IDLE: d.sw = d.sw;
      SW_BUSY: begin
        d.hit = (q.res[q.sel] == q.swap_exp);
        if (q.res[q.sel] == q.swap_exp) begin
          d.res[q.sel] = q.swap_new;
        end
        d.done = 1'b1;
        d.sw = SW_IDLE;
      end
      default: d.sw = SW_IDLE;
    endcase

    for (int u = 0; u < NUM_UNITS; u++) begin
      if (tx_event_in[u].start) begin
        d.cnt[u] = '0;
      end else if (tx_event_in[u].ack && tx_event_in[u].retryable) begin
        if (q.cnt[u] < limit_of(q.limits, u)) begin
          d.cnt[u] = 4'(q.cnt[u] + 4'h1);
          d.retry[u] = 1'b1;
        end else begin
          d.exhausted[u] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign host_rsp_out = q.rsp;
  assign bus_resource_out = q.res;
  assign swap_match_out = q.hit;

  always_comb begin
    for (int k = 0; k < NUM_UNITS; k++) begin
      tx_verdict_out[k].retry = q.retry[k];
      tx_verdict_out[k].exhausted = q.exhausted[k];
    end
  end

  genvar gu;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence ctl_write_idle;
    host_req_in.wr && host_req_in.addr == OFF_SWAP_CTL && q.sw == SW_IDLE;
  endsequence

  sequence swap_finishes;
    q.sw == SW_BUSY ##1 (q.done && q.sw == SW_IDLE);
  endsequence

  sequence write_then_read(logic [7:0] off);
    (host_req_in.wr && host_req_in.addr == off)
      ##1 (host_req_in.rd && host_req_in.addr == off);
  endsequence

  a_done_cleared: assert property (
    ctl_write_idle |=> !q.done
  ) else $error("completion flag not cleared by control write");

  a_done_raised: assert property (
    ctl_write_idle |=> swap_finishes
  ) else $error("swap did not complete two cycles after request");

  a_swap_stores: assert property (
    (q.sw == SW_BUSY && q.res[q.sel] == q.swap_exp)
      |=> q.res[$past(q.sel)] == $past(q.swap_new) && q.hit
  ) else $error("matching swap did not store new value");

  a_swap_keeps: assert property (
    (q.sw == SW_BUSY && q.res[q.sel] != q.swap_exp)
      |=> $stable(q.res) && !q.hit
  ) else $error("mismatching swap altered a resource");

  a_sel_loaded: assert property (
    ctl_write_idle |=> q.sel == $past(host_req_in.wdata[SEL_W-1:0])
  ) else $error("selector not loaded from control write");

  a_retry_zeros: assert property (
    (host_req_in.rd && host_req_in.addr == OFF_RETRY)
      |=> host_rsp_out.valid && host_rsp_out.data[31:12] == 20'h00000
  ) else $error("retry register upper bits not zero");

  a_ctl_zeros: assert property (
    (host_req_in.rd && host_req_in.addr == OFF_SWAP_CTL)
      |=> host_rsp_out.data[30:2] == 29'h0 &&
          host_rsp_out.data[DONE_BIT] == $past(q.done)
  ) else $error("control register readback wrong");

  a_limit_write: assert property (
    write_then_read(OFF_RETRY)
      |=> host_rsp_out.data[LIMITS_W-1:0] ==
          $past(host_req_in.wdata[LIMITS_W-1:0], 2)
  ) else $error("retry limits not taken from write");

  a_new_readback: assert property (
    write_then_read(OFF_SWAP_NEW)
      |=> host_rsp_out.valid &&
          host_rsp_out.data == $past(host_req_in.wdata, 2)
  ) else $error("new-value word readback wrong");

  a_exp_readback: assert property (
    write_then_read(OFF_SWAP_EXP)
      |=> host_rsp_out.valid &&
          host_rsp_out.data == $past(host_req_in.wdata, 2)
  ) else $error("expected-value word readback wrong");

  a_phys_field: assert property (
    (host_req_in.wr && host_req_in.addr == OFF_RETRY)
      |=> limit_of(q.limits, UNIT_PHYS_RESP) ==
          $past(host_req_in.wdata[PHYS_LIMIT_LSB +: LIMIT_W])
  ) else $error("physical response limit field misplaced");

  a_resp_field: assert property (
    (host_req_in.wr && host_req_in.addr == OFF_RETRY)
      |=> limit_of(q.limits, UNIT_AT_RESP) ==
          $past(host_req_in.wdata[ATRESP_LIMIT_LSB +: LIMIT_W])
  ) else $error("transmit response limit field misplaced");

  a_req_field: assert property (
    (host_req_in.wr && host_req_in.addr == OFF_RETRY)
      |=> limit_of(q.limits, UNIT_AT_REQ) ==
          $past(host_req_in.wdata[ATREQ_LIMIT_LSB +: LIMIT_W])
  ) else $error("transmit request limit field misplaced");

  a_done_holds: assert property (
    (q.done && !(host_req_in.wr && host_req_in.addr == OFF_SWAP_CTL))
      |=> q.done
  ) else $error("completion flag dropped without control write");

  a_busy_ignores: assert property (
    q.sw == SW_BUSY
      |=> q.sw == SW_IDLE && q.done && $stable(q.sel)
  ) else $error("control write during swap was not ignored");

  a_busy_read: assert property (
    (q.sw == SW_BUSY && host_req_in.rd &&
     host_req_in.addr == OFF_SWAP_CTL)
      |=> host_rsp_out.valid && !host_rsp_out.data[DONE_BIT]
  ) else $error("pending swap read back as complete");

  a_sel_readback: assert property (
    (host_req_in.rd && host_req_in.addr == OFF_SWAP_CTL)
      |=> host_rsp_out.data[SEL_W-1:0] == $past(q.sel)
  ) else $error("selector readback wrong");

  a_res_quiet: assert property (
    q.sw != SW_BUSY |=> $stable(q.res) && $stable(q.hit)
  ) else $error("resource changed outside a swap");

  a_state_legal: assert property (
    q.sw == SW_IDLE || q.sw == SW_BUSY
  ) else $error("swap state machine left its legal codes");

  for (gu = 0; gu < NUM_UNITS; gu++) begin : g_chk
    a_retry_bound: assert property (
      (!tx_event_in[gu].start && tx_event_in[gu].ack &&
       tx_event_in[gu].retryable)
        |=> (q.retry[gu] ==
             ($past(q.cnt[gu]) < limit_of($past(q.limits), gu))) &&
            (q.exhausted[gu] != q.retry[gu])
    ) else $error("retry verdict disagrees with limit");

    a_other_ack: assert property (
      (!tx_event_in[gu].start && tx_event_in[gu].ack &&
       !tx_event_in[gu].retryable)
        |=> !q.retry[gu] && !q.exhausted[gu] && $stable(q.cnt[gu])
    ) else $error("non-retryable ack consumed a retry");

    a_start_clears: assert property (
      tx_event_in[gu].start
        |=> q.cnt[gu] == '0 && !q.retry[gu] && !q.exhausted[gu]
    ) else $error("packet start did not clear retry count");

    a_no_ack_quiet: assert property (
      !tx_event_in[gu].ack |=> !q.retry[gu] && !q.exhausted[gu]
    ) else $error("verdict without an acknowledge");

    a_retry_counts: assert property (
      (!tx_event_in[gu].start && tx_event_in[gu].ack &&
       tx_event_in[gu].retryable)
        |=> q.cnt[gu] == (q.retry[gu] ? 4'($past(q.cnt[gu]) + 4'h1)
                                       : $past(q.cnt[gu]))
    ) else $error("retry count did not follow verdict");
  end

endmodule

`default_nettype wire

// ===== tb/host_partner.sv
`timescale 1ns/1ps
`default_nettype none

module host_partner
  import swap_retry_pkg::*;
(
  // Clock and answer
  input wire logic clk_in,
  input wire host_rsp_t rsp_in,
  // Request
  output var host_req_t req_out
);
  initial req_out = '0;

  // Strobe high for one edge; answer lands right after it
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_in);
    req_out.rd = 1'b1;
    req_out.addr = a;
    @(negedge clk_in);
    req_out.rd = 1'b0;
    req_out.addr = ~a;
    d = rsp_in.valid ? rsp_in.data : 'x;
  endtask

  // Read lands in the busy cycle so a cleared flag can be seen
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] w,
                       output logic [31:0] d);
    @(negedge clk_in);
    req_out.wr = 1'b1;
    req_out.addr = a;
    req_out.wdata = w;
    @(negedge clk_in);
    req_out.wr = 1'b0;
    req_out.rd = 1'b1;
    req_out.wdata = ~w;
    @(negedge clk_in);
    req_out.rd = 1'b0;
    req_out.addr = ~a;
    d = rsp_in.valid ? rsp_in.data : 'x;
  endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import swap_retry_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  host_req_t req;
  host_rsp_t rsp;
  tx_event_t [NUM_UNITS-1:0] ev = '0;
  tx_verdict_t [NUM_UNITS-1:0] vd;
  logic [3:0][31:0] res;
  logic [3:0][31:0] mdl;
  logic hit;
  logic match;
  logic [31:0] q, e, n, c;
  int lim;
  int u;
  int n_errors = 0;
  int n_compared = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  async_retry_and_csr_swap_regs dut (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .host_req_in(req),
    .host_rsp_out(rsp),
    .tx_event_in(ev),
    .tx_verdict_out(vd),
    .bus_resource_out(res),
    .swap_match_out(match)
  );

  host_partner host (.clk_in(ref_clk_in), .rsp_in(rsp), .req_out(req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One event pulse on unit k; verdict checked the cycle after
  task automatic tx(input int k, input logic [2:0] ev_v,
                    input logic [1:0] ex);
    @(negedge ref_clk_in);
    ev[k] = ev_v;
    @(negedge ref_clk_in);
    ev[k] = '0;
    chk(32'(vd[k]), 32'(ex));
  endtask

  // Fixed-latency bench, so a hang can only be a stuck run
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h031a));
    mdl = '0;
    repeat (20) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    host.rd(OFF_RETRY, q);
    chk(q, 32'h0000_0000);
    host.rd(OFF_SWAP_CTL, q);
    chk(q, 32'h8000_0000);
    host.rd(8'h04, q);
    chk(q, 32'h0000_0000);
    host.wr_rd(8'h18, 32'hffff_ffff, q);
    chk(q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      e = (i < 4 || (i < 7 && $urandom_range(1))) ? mdl[i%4] : ~mdl[i%4];
      n = $urandom;
      c = $urandom;
      host.wr_rd(OFF_SWAP_EXP, e, q);
      chk(q, e);
      host.wr_rd(OFF_SWAP_NEW, n, q);
      chk(q, n);
      host.wr_rd(OFF_SWAP_CTL, {c[31:2], 2'(i)}, q);
      chk(q, {30'h0, 2'(i)});
      hit = (e === mdl[i%4]);
      if (hit) mdl[i%4] = n;
      host.rd(OFF_SWAP_CTL, q);
      chk(q, {1'b1, 29'h0, 2'(i)});
      chk(32'(match), 32'(hit));
      for (int k = 0; k < 4; k++) chk(res[k], mdl[k]);
    end
    for (int it = 0; it < 4; it++) begin
      c = $urandom;
      if (it == 0) c[3:0] = 4'h0;
      u = it % 3;
      lim = int'(c[u*4 +: 4]);
      host.wr_rd(OFF_RETRY, c, q);
      chk(q, c & 32'h0000_0fff);
      tx(u, 3'b100, 2'b00);
      for (int k = 0; k <= lim; k++) begin
        tx(u, 3'b010, 2'b00);
        tx(u, 3'b011, (k < lim) ? 2'b10 : 2'b01);
      end
    end
    test_done();
  end
endmodule

`default_nettype wire
